// ==== core/prm_regs.vh ====
`ifndef PRM_REGS_VH
`define PRM_REGS_VH

// ****************************************
// Register map, byte addresses
// ****************************************
`define PRM_CMD_OFS      12'h030
`define PRM_DATA_OFS     12'h034

// ****************************************
// Command register fields
// ****************************************
`define PRM_BUSY_BIT     31
`define PRM_OP_HI        30
`define PRM_OP_LO        28
`define PRM_TOUT_BIT     10
`define PRM_LOADED_BIT   9
`define PRM_LOC_HI       8

// ****************************************
// Reset values
// ****************************************
`define PRM_OP_RST       3'h0
`define PRM_LOC_RST      9'h000
`define PRM_DATA_RST     8'h00

// ****************************************
// Command opcodes
// ****************************************
`define PRM_OP_READ      3'h0
`define PRM_OP_LOCK      3'h1
`define PRM_OP_UNLOCK    3'h2
`define PRM_OP_WRITE     3'h3
`define PRM_OP_FILL      3'h4
`define PRM_OP_ERASE     3'h5
`define PRM_OP_CLEAR     3'h6
`define PRM_OP_RELOAD    3'h7

// ****************************************
// Serial frame codes: start bit plus two opcode bits
// ****************************************
`define PRM_MW_READ      3'h6
`define PRM_MW_WRITE     3'h5
`define PRM_MW_ERASE     3'h7
`define PRM_MW_CTRL      3'h4
`define PRM_MW_UNLOCK    2'h3
`define PRM_MW_LOCK      2'h0
`define PRM_MW_CLEAR     2'h2
`define PRM_MW_FILL      2'h1
`define PRM_HDR_BITS     5'h0C
`define PRM_FULL_BITS    5'h14

// ****************************************
// Load image and timing
// ****************************************
`define PRM_SIGNATURE    8'hA5
`define PRM_LOAD_LAST    9'h01F
`define PRM_TIMEOUT_MS   24'h00001E
`define PRM_CLK_KHZ      24'h00C350
`define PRM_TIMEOUT_CYC  (`PRM_TIMEOUT_MS * `PRM_CLK_KHZ)
`define PRM_CLK_NS       20
`define PRM_SCK_HALF_NS  260
`define PRM_SCK_HALF_CYC ((`PRM_SCK_HALF_NS + `PRM_CLK_NS - 1) / `PRM_CLK_NS)

// ****************************************
// Bus answers
// ****************************************
`define PRM_RESP_OKAY    2'h0
`define PRM_RESP_SLVERR  2'h2

`endif

// ==== core/prm_serial_engine.v ====
`timescale 1ns/1ps
`default_nettype none
`include "prm_regs.vh"

module prm_serial_engine #(
   parameter [23:0] TIMEOUT_CYC = `PRM_TIMEOUT_CYC
) (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        resetn,
   // Request
   input  wire        start,
   input  wire [19:0] frame,
   input  wire [4:0]  nbits,
   input  wire        poll,
   // Answer
   output reg         done,
   output reg         timed_out,
   output reg  [7:0]  rx,
   // Serial pins
   output reg         prom_cs,
   output reg         prom_sck,
   output reg         prom_mosi,
   input  wire        prom_miso
);

   localparam integer HALF_I = `PRM_SCK_HALF_CYC - 1;
   localparam [7:0] HALF_M1 = HALF_I[7:0];
   localparam [2:0] E_IDLE = 3'h0;
   localparam [2:0] E_LOW  = 3'h1;
   localparam [2:0] E_HIGH = 3'h2;
   localparam [2:0] E_GAP  = 3'h3;
   localparam [2:0] E_POLL = 3'h4;

   reg [2:0]  state;
   reg [7:0]  div;
   reg [4:0]  bits;
   reg [19:0] sreg;
   reg        poll_q;
   reg [23:0] to_cnt;

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state     <= E_IDLE;
         div       <= 8'h00;
         bits      <= 5'h00;
         sreg      <= 20'h00000;
         poll_q    <= 1'b0;
         to_cnt    <= 24'h000000;
         done      <= 1'b0;
         timed_out <= 1'b0;
         rx        <= 8'h00;
         prom_cs   <= 1'b0;
         prom_sck  <= 1'b0;
         prom_mosi <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state)
            E_IDLE: begin
               if (start) begin
                  prom_cs   <= 1'b1;
                  prom_mosi <= frame[19];
                  sreg      <= {frame[18:0], 1'b0};
                  bits      <= nbits;
                  poll_q    <= poll;
                  timed_out <= 1'b0;
                  div       <= 8'h00;
                  state     <= E_LOW;
               end
            end
            E_LOW: begin
               if (div == HALF_M1) begin
                  div      <= 8'h00;
                  prom_sck <= 1'b1;
                  state    <= E_HIGH;
               end else begin
                  div <= div + 8'h01;
               end
            end
            E_HIGH: begin
               if (div == HALF_M1) begin
                  // Read data leaves the part on the rising edge
                  div      <= 8'h00;
                  prom_sck <= 1'b0;
                  rx       <= {rx[6:0], prom_miso};
                  bits     <= bits - 5'h01;
                  if (bits == 5'h01) begin
                     prom_cs   <= 1'b0;
                     prom_mosi <= 1'b0;
                     if (poll_q) begin
                        state <= E_GAP;
                     end else begin
                        done  <= 1'b1;
                        state <= E_IDLE;
                     end
                  end else begin
                     prom_mosi <= sreg[19];
                     sreg      <= {sreg[18:0], 1'b0};
                     state     <= E_LOW;
                  end
               end else begin
                  div <= div + 8'h01;
               end
            end
            E_GAP: begin
               // Chip select low time before the ready poll
               if (div == HALF_M1) begin
                  div     <= 8'h00;
                  prom_cs <= 1'b1;
                  to_cnt  <= 24'h000000;
                  state   <= E_POLL;
               end else begin
                  div <= div + 8'h01;
               end
            end
            E_POLL: begin
               if (prom_miso) begin
                  prom_cs <= 1'b0;
                  done    <= 1'b1;
                  state   <= E_IDLE;
               end else if (to_cnt == TIMEOUT_CYC - 24'h000001) begin
                  prom_cs   <= 1'b0;
                  timed_out <= 1'b1;
                  done      <= 1'b1;
                  state     <= E_IDLE;
               end else begin
                  to_cnt <= to_cnt + 24'h000001;
               end
            end
            default: begin
               state <= E_IDLE;
            end
         endcase
      end
   end

endmodule // prm_serial_engine

`default_nettype wire

// ==== core/prm_cmd_port.v ====
`timescale 1ns/1ps
`default_nettype none
`include "prm_regs.vh"

module prm_cmd_port #(
   parameter [23:0] TIMEOUT_CYC = `PRM_TIMEOUT_CYC
) (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        resetn,
   // Bus reset event from the USB side
   input  wire        usb_bus_reset,
   // AXI4-Lite write address
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read address
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   // AXI4-Lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Configuration image delivered by a good load
   output reg         cfg_load_valid,
   output reg  [8:0]  cfg_load_addr,
   output reg  [7:0]  cfg_load_data,
   // Serial memory pins
   output wire        prom_cs,
   output wire        prom_sck,
   output wire        prom_mosi,
   input  wire        prom_miso
);

   // ****************************************
   // Controller states
   // ****************************************
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_OP   = 2'h1;
   localparam [1:0] ST_SIG  = 2'h2;
   localparam [1:0] ST_LOAD = 2'h3;

   reg [1:0]  state;
   reg        prom_op_busy;
   reg [2:0]  prom_op_code;
   reg [8:0]  prom_op_location;
   reg        prom_op_timeout_flag;
   reg        prom_loaded_flag;
   reg [7:0]  prom_data_reg;
   reg [2:0]  run_code;
   reg        go_pending;
   reg        boot_pending;
   reg        usb_pending;
   reg [8:0]  load_idx;
   reg        eng_start;
   reg [19:0] eng_frame;
   reg [4:0]  eng_nbits;
   reg        eng_poll;
   reg        aw_held;
   reg [11:0] aw_addr;
   reg        w_held;
   reg [31:0] w_data;
   reg [3:0]  w_strb;

   wire       eng_done;
   wire       eng_timed_out;
   wire [7:0] eng_rx;
   wire       do_wr;
   wire       wr_cmd;
   wire       wr_dat;
   wire       ar_take;
   wire       start_req;

   // ****************************************
   // Serial frame builder
   // ****************************************
   // Header is start bit, opcode pair and nine address bits; data follows
   function [19:0] mw_frame;
      input [2:0] op;
      input [8:0] loc;
      input [7:0] dat;
      begin
         case (op)
            `PRM_OP_READ:   mw_frame = {`PRM_MW_READ, loc, 8'h00};
            `PRM_OP_LOCK:   mw_frame = {`PRM_MW_CTRL, `PRM_MW_LOCK, 7'h00, 8'h00};
            `PRM_OP_UNLOCK: mw_frame = {`PRM_MW_CTRL, `PRM_MW_UNLOCK, 7'h00, 8'h00};
            `PRM_OP_WRITE:  mw_frame = {`PRM_MW_WRITE, loc, dat};
            `PRM_OP_FILL:   mw_frame = {`PRM_MW_CTRL, `PRM_MW_FILL, 7'h00, dat};
            `PRM_OP_ERASE:  mw_frame = {`PRM_MW_ERASE, loc, 8'h00};
            `PRM_OP_CLEAR:  mw_frame = {`PRM_MW_CTRL, `PRM_MW_CLEAR, 7'h00, 8'h00};
            default:        mw_frame = {`PRM_MW_READ, loc, 8'h00};
         endcase
      end
   endfunction

   // Lock state lives in the part; no shadow is kept here, so a
   // locked part simply ignores the frame and the poll answers ready
   function [4:0] mw_bits;
      input [2:0] op;
      begin
         case (op)
            `PRM_OP_READ,
            `PRM_OP_WRITE,
            `PRM_OP_FILL,
            `PRM_OP_RELOAD: mw_bits = `PRM_FULL_BITS;
            default:        mw_bits = `PRM_HDR_BITS;
         endcase
      end
   endfunction

   // Only programming frames wait for the ready answer and can time out
   function mw_poll;
      input [2:0] op;
      begin
         case (op)
            `PRM_OP_WRITE,
            `PRM_OP_FILL,
            `PRM_OP_ERASE,
            `PRM_OP_CLEAR: mw_poll = 1'b1;
            default:       mw_poll = 1'b0;
         endcase
      end
   endfunction

   // ****************************************
   // AXI4-Lite slave
   // ****************************************
   assign do_wr   = aw_held && w_held && !s_axi_bvalid;
   assign wr_cmd  = do_wr && ({aw_addr[11:2], 2'b00} == `PRM_CMD_OFS);
   assign wr_dat  = do_wr && ({aw_addr[11:2], 2'b00} == `PRM_DATA_OFS);
   assign ar_take = s_axi_arvalid && s_axi_arready;
   // Writing zero to busy, or one while already busy, starts nothing
   assign start_req = wr_cmd && w_strb[3] && w_data[`PRM_BUSY_BIT]
                      && !prom_op_busy;

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `PRM_RESP_OKAY;
         aw_held       <= 1'b0;
         aw_addr       <= 12'h000;
         w_held        <= 1'b0;
         w_data        <= 32'h00000000;
         w_strb        <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_held       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
         end else if (!aw_held && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_held       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
         end else if (!w_held && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (do_wr) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_cmd || wr_dat) ? `PRM_RESP_OKAY : `PRM_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `PRM_RESP_OKAY;
      end else begin
         if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `PRM_RESP_OKAY;
            case ({s_axi_araddr[11:2], 2'b00})
               `PRM_CMD_OFS:  s_axi_rdata <= {prom_op_busy, prom_op_code, 17'h00000,
                                              prom_op_timeout_flag, prom_loaded_flag,
                                              prom_op_location};
               `PRM_DATA_OFS: s_axi_rdata <= {24'h000000, prom_data_reg};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `PRM_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ****************************************
   // Registers and operation sequencer
   // ****************************************
   // Flags: clears come first in the block so a same-cycle set wins
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state                <= ST_IDLE;
         prom_op_busy         <= 1'b1;
         prom_op_code         <= `PRM_OP_RST;
         prom_op_location     <= `PRM_LOC_RST;
         prom_op_timeout_flag <= 1'b0;
         prom_loaded_flag     <= 1'b0;
         prom_data_reg        <= `PRM_DATA_RST;
         run_code             <= `PRM_OP_RST;
         go_pending           <= 1'b0;
         boot_pending         <= 1'b1;
         usb_pending          <= 1'b0;
         load_idx             <= 9'h000;
         eng_start            <= 1'b0;
         eng_frame            <= 20'h00000;
         eng_nbits            <= 5'h00;
         eng_poll             <= 1'b0;
         cfg_load_valid       <= 1'b0;
         cfg_load_addr        <= 9'h000;
         cfg_load_data        <= 8'h00;
      end else begin
         eng_start      <= 1'b0;
         cfg_load_valid <= 1'b0;

         // Software side of the command and data registers
         if (wr_cmd) begin
            if (w_strb[3]) begin
               prom_op_code <= w_data[`PRM_OP_HI:`PRM_OP_LO];
            end
            if (w_strb[1]) begin
               prom_op_location[8] <= w_data[`PRM_LOC_HI];
               if (w_data[`PRM_TOUT_BIT]) begin
                  prom_op_timeout_flag <= 1'b0;
               end
               if (w_data[`PRM_LOADED_BIT]) begin
                  prom_loaded_flag <= 1'b0;
               end
            end
            if (w_strb[0]) begin
               prom_op_location[7:0] <= w_data[7:0];
            end
         end
         if (wr_dat && w_strb[0]) begin
            prom_data_reg <= w_data[7:0];
         end
         if (start_req) begin
            prom_op_busy <= 1'b1;
            go_pending   <= 1'b1;
            run_code     <= w_strb[3] ? w_data[`PRM_OP_HI:`PRM_OP_LO] : prom_op_code;
         end

         case (state)
            ST_IDLE: begin
               if (boot_pending || usb_pending) begin
                  boot_pending <= 1'b0;
                  usb_pending  <= 1'b0;
                  eng_start    <= 1'b1;
                  eng_frame    <= mw_frame(`PRM_OP_READ, 9'h000, 8'h00);
                  eng_nbits    <= `PRM_FULL_BITS;
                  eng_poll     <= 1'b0;
                  state        <= ST_SIG;
               end else if (go_pending) begin
                  // Operation runs on a copy of opcode, location and data
                  go_pending <= 1'b0;
                  eng_start  <= 1'b1;
                  eng_nbits  <= mw_bits(run_code);
                  eng_poll   <= mw_poll(run_code);
                  if (run_code == `PRM_OP_RELOAD) begin
                     eng_frame <= mw_frame(`PRM_OP_READ, 9'h000, 8'h00);
                     state     <= ST_SIG;
                  end else begin
                     eng_frame <= mw_frame(run_code, prom_op_location, prom_data_reg);
                     state     <= ST_OP;
                  end
               end
            end
            ST_OP: begin
               if (eng_done) begin
                  if (run_code == `PRM_OP_READ) begin
                     prom_data_reg <= eng_rx;
                  end
                  if (eng_timed_out) begin
                     prom_op_timeout_flag <= 1'b1;
                  end
                  prom_op_busy <= usb_pending;
                  state        <= ST_IDLE;
               end
            end
            ST_SIG: begin
               if (eng_done) begin
                  if (eng_rx == `PRM_SIGNATURE) begin
                     load_idx  <= 9'h001;
                     eng_start <= 1'b1;
                     eng_frame <= mw_frame(`PRM_OP_READ, 9'h001, 8'h00);
                     eng_nbits <= `PRM_FULL_BITS;
                     eng_poll  <= 1'b0;
                     state     <= ST_LOAD;
                  end else begin
                     // Blank part: nothing is delivered, old setup stays
                     prom_op_busy <= usb_pending;
                     state        <= ST_IDLE;
                  end
               end
            end
            ST_LOAD: begin
               if (eng_done) begin
                  cfg_load_valid <= 1'b1;
                  cfg_load_addr  <= load_idx;
                  cfg_load_data  <= eng_rx;
                  if (load_idx == `PRM_LOAD_LAST) begin
                     prom_loaded_flag <= 1'b1;
                     prom_op_busy     <= usb_pending;
                     state            <= ST_IDLE;
                  end else begin
                     load_idx  <= load_idx + 9'h001;
                     eng_start <= 1'b1;
                     eng_frame <= mw_frame(`PRM_OP_READ, load_idx + 9'h001, 8'h00);
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase

         // A bus reset raises busy at once; the load follows the current operation
         if (usb_bus_reset) begin
            prom_op_busy <= 1'b1;
            usb_pending  <= 1'b1;
         end
      end
   end

   // ****************************************
   // Serial engine
   // ****************************************
   prm_serial_engine #(
      .TIMEOUT_CYC (TIMEOUT_CYC)
   ) u_engine (
      .ref_clk   (ref_clk),
      .resetn    (resetn),
      .start     (eng_start),
      .frame     (eng_frame),
      .nbits     (eng_nbits),
      .poll      (eng_poll),
      .done      (eng_done),
      .timed_out (eng_timed_out),
      .rx        (eng_rx),
      .prom_cs   (prom_cs),
      .prom_sck  (prom_sck),
      .prom_mosi (prom_mosi),
      .prom_miso (prom_miso)
   );

endmodule // prm_cmd_port

`default_nettype wire

// ==== sim/prm_cmd_port_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module prm_asserts (
   input wire logic        ref_clk, resetn, cfg_load_valid, prom_sck, prom_mosi, prom_cs,
   input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
   input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
   input wire logic        s_axi_rvalid, s_axi_rready,
   input wire logic [1:0]  s_axi_bresp, s_axi_rresp,
   input wire logic [11:0] s_axi_araddr,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [8:0]  cfg_load_addr
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   property p_bv;
      $rose(s_axi_bvalid) |->
         $past(s_axi_awvalid && s_axi_awready, 2) || $past(s_axi_wvalid && s_axi_wready, 2);
   endproperty
   property p_rv; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   property p_rh; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   property p_aw; s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*3]; endproperty
   property p_cf; cfg_load_valid |-> cfg_load_addr inside {[9'h001:9'h01F]}; endproperty
   property p_um;
      s_axi_arvalid && s_axi_arready && !(s_axi_araddr[11:3] == 9'h006) |=>
         s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
   endproperty
   // Serial data may only move while the clock is low
   property p_mo; prom_sck && $past(prom_sck) |-> $stable(prom_mosi); endproperty
   a_bv: assert property (p_bv) else $error("write answer late");
   a_rv: assert property (p_rv) else $error("read answer late");
   a_bh: assert property (p_bh) else $error("write answer dropped");
   a_rh: assert property (p_rh) else $error("read data moved");
   a_aw: assert property (p_aw) else $error("second write taken");
   a_cf: assert property (p_cf) else $error("load index out of range");
   a_um: assert property (p_um) else $error("unmapped read answered");
   a_mo: assert property (p_mo) else $error("data moved in clock high");
   c_cf: cover property (cfg_load_valid);
   c_um: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   c_cs: cover property ($fell(prom_cs));
endmodule // prm_asserts
bind prm_cmd_port prm_asserts i_chk (.*);
`default_nettype wire

// ==== sim/prm_prom_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module prm_prom_model (
   input  wire logic cs, sck, mosi, present,
   output wire logic miso
);
   logic [7:0]  mem [0:511];
   logic [19:0] sh = 0;
   logic [11:0] hdr = 0;
   logic        unl = 0;
   int          n = 0;
   initial begin
      foreach (mem[i]) mem[i] = 8'hFF;
      mem[0] = 8'hA5;
   end
   // Pulled high when idle; a missing part leaves the line low
   assign miso = !present ? 1'b0 :
                 (cs && n > 12 && hdr[11:9] == 3'h6) ? mem[hdr[8:0]][20 - n] : 1'b1;
   always @(posedge cs) n = 0;
   always @(posedge sck) if (cs) begin
      sh = {sh[18:0], mosi};
      n++;
      if (n == 12) hdr = sh[11:0];
   end
   always @(negedge cs) if (present && n >= 12) case (hdr[11:9])
      3'h5: if (unl) mem[hdr[8:0]] = sh[7:0];
      3'h7: if (unl) mem[hdr[8:0]] = 8'hFF;
      3'h4: case (hdr[8:7])
         2'h3: unl = 1;
         2'h0: unl = 0;
         default: if (unl) foreach (mem[i]) mem[i] = hdr[7] ? sh[7:0] : 8'hFF;
      endcase
   endcase
endmodule // prm_prom_model
`default_nettype wire

// ==== sim/serial_prom_command_port_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "prm_regs.vh"
module serial_prom_command_port_tb;
   logic        ref_clk = 0, resetn = 0, usb_bus_reset = 0, present = 1;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, v, lf = 32'h5A0E;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [8:0]  a;
   logic [7:0]  d;
   logic [65:0] q [$];
   logic [1:0]  bq [$];
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire         cfg_load_valid, prom_cs, prom_sck, prom_mosi, prom_miso;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire  [8:0]  cfg_load_addr;
   wire  [7:0]  cfg_load_data;
   int          n_errors = 0, check_count = 0, n_cfg = 0;
   always #10 ref_clk = ~ref_clk;
   prm_cmd_port #(.TIMEOUT_CYC(24'h0000C8)) i_dut (.*);
   prm_prom_model i_prom (.cs(prom_cs), .sck(prom_sck), .mosi(prom_mosi),
                          .present(present), .miso(prom_miso));
   task automatic chk(input string s, input logic [31:0] g, x);
      check_count++;
      if (g !== x) begin
         n_errors++;
         $display("CHECK FAILED %s exp %h got %h", s, x, g);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic hang(input bit ok);
      if (!ok) begin
         n_errors++;
         conclude();
      end
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic wr(input logic [11:0] ad, input logic [31:0] x, input logic [1:0] r = 0);
      bit ok = 0;
      @(posedge ref_clk);
      bq.push_back(r);
      s_axi_awaddr <= ad;
      s_axi_wdata <= x;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= check_count[0];
      for (int i = 0; i < 40 && !ok; i++) begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
         ok = s_axi_bvalid && s_axi_bready;
         if (!s_axi_bready) s_axi_bready <= s_axi_bvalid;
      end
      s_axi_bready <= 0;
      hang(ok);
   endtask
   task automatic rd(input logic [11:0] ad, input logic [31:0] m, x, input logic [1:0] r = 0);
      bit ok = 0;
      @(posedge ref_clk);
      q.push_back({r, m, x});
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1;
      s_axi_rready <= check_count[0];
      for (int i = 0; i < 40 && !ok; i++) begin
         @(posedge ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 0;
         ok = s_axi_rvalid && s_axi_rready;
         v = s_axi_rdata;
         if (!s_axi_rready) s_axi_rready <= s_axi_rvalid;
      end
      s_axi_rready <= 0;
      hang(ok);
   endtask
   task automatic idle;
      bit ok = 0;
      for (int i = 0; i < 9000 && !ok; i++) begin
         rd(`PRM_CMD_OFS, 0, 0);
         ok = !v[31];
      end
      hang(ok);
   endtask
   task automatic op(input logic [2:0] c, input logic [8:0] l);
      wr(`PRM_CMD_OFS, {1'b1, c, 19'h0, l});
      idle();
      rd(`PRM_CMD_OFS, 32'hF00001FF, {1'b0, c, 19'h0, l});
   endtask
   task automatic peek(input logic [8:0] l, input logic [7:0] x);
      op(`PRM_OP_READ, l);
      rd(`PRM_DATA_OFS, 32'hFFFFFFFF, {24'h0, x});
   endtask
   always @(posedge ref_clk) if (s_axi_rvalid && s_axi_rready) begin
      logic [65:0] e;
      e = q.pop_front();
      if (e[63:32] != 0) chk("rdata", s_axi_rdata & e[63:32], e[31:0]);
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, e[65:64]});
   end
   always @(posedge ref_clk) if (s_axi_bvalid && s_axi_bready)
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
   always @(posedge ref_clk) if (cfg_load_valid) begin
      n_cfg++;
      chk("cfg_data", {24'h0, cfg_load_data}, 32'hFF);
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      resetn <= 1;
      rd(`PRM_CMD_OFS, 32'h80000000, 32'h80000000);
      idle();
      rd(`PRM_CMD_OFS, 32'h80000200, 32'h00000200);
      wr(`PRM_CMD_OFS, 32'h00000200);
      rd(`PRM_CMD_OFS, 32'h80000200, 32'h0);
      op(`PRM_OP_RELOAD, 9'h000);
      rd(`PRM_CMD_OFS, 32'h00000200, 32'h00000200);
      $display("boot and reload done");
      op(`PRM_OP_UNLOCK, 9'h000);
      repeat (2) begin
         lf = lfsr(lf);
         a = lf[8:0] | 9'h020;
         d = lf[23:16];
         wr(`PRM_DATA_OFS, {24'h0, d});
         op(`PRM_OP_WRITE, a);
         wr(`PRM_DATA_OFS, 32'h0);
         peek(a, d);
      end
      op(`PRM_OP_LOCK, 9'h000);
      wr(`PRM_DATA_OFS, {24'h0, ~d});
      op(`PRM_OP_WRITE, a);
      peek(a, d);
      op(`PRM_OP_UNLOCK, 9'h000);
      op(`PRM_OP_ERASE, a);
      peek(a, 8'hFF);
      wr(`PRM_DATA_OFS, {24'h0, d});
      op(`PRM_OP_FILL, 9'h000);
      peek(a ^ 9'h0C3, d);
      op(`PRM_OP_CLEAR, 9'h000);
      peek(a, 8'hFF);
      wr(`PRM_CMD_OFS, 32'h00000200);
      op(`PRM_OP_RELOAD, 9'h000);
      rd(`PRM_CMD_OFS, 32'h00000200, 32'h0);
      $display("store and erase done");
      present <= 0;
      op(`PRM_OP_WRITE, a);
      rd(`PRM_CMD_OFS, 32'h00000400, 32'h00000400);
      present <= 1;
      rd(12'h0F0, 32'hFFFFFFFF, 32'h0, 2'h2);
      wr(12'h0F0, 32'h0, 2'h2);
      usb_bus_reset <= 1;
      @(posedge ref_clk);
      usb_bus_reset <= 0;
      rd(`PRM_CMD_OFS, 32'h80000000, 32'h80000000);
      idle();
      $display("timeout and bus reset done");
      chk("cfg_count", n_cfg, 62);
      conclude();
   end
endmodule // serial_prom_command_port_tb
`default_nettype wire
